/* File: shared/fwp_cfg.svh */
// constants for the flash write-enable and sector protect block
`ifndef FWP_CFG_SVH
`define FWP_CFG_SVH

// ============================================================
// command opcodes
`define FWP_OP_LATCH_SET    8'h06
`define FWP_OP_LATCH_CLEAR  8'h04
`define FWP_OP_PROTECT      8'h36
`define FWP_OP_UNPROTECT    8'h39

// ============================================================
// frame layout
`define FWP_OPCODE_BYTES    3'h1
`define FWP_ADDR_BYTES      3'h4
`define FWP_BYTE_SAT        3'h4

// ============================================================
// sector geometry and reset values
`define FWP_SECTORS         16
`define FWP_SECTOR_LSB      16
`define FWP_SECTOR_MSB      19
`define FWP_PROT_RST        1'b1
`define FWP_LATCH_RST       1'b0

`endif

/* File: shared/fwp_pkg.sv */
// types shared by the flash write-enable and sector protect block
package fwp_pkg;

    // ============================================================
    // command tracker states
    typedef enum logic [1:0] {
        FWP_ST_IDLE  = 2'b00,
        FWP_ST_FRAME = 2'b01,
        FWP_ST_EXEC  = 2'b10
    } fwp_state_e;

    // one protection bit per physical sector
    typedef logic [15:0] fwp_sect_t;
    typedef logic [23:0] fwp_addr_t;
    typedef logic [3:0]  fwp_sidx_t;

endpackage

/* File: hw/fwp_link_rx.sv */
// serial link receiver: gathers opcode and address on the link clock
`include "fwp_cfg.svh"
module fwp_link_rx (
    input  wire logic           sck_in,
    input  wire logic           rst_in,
    input  wire logic           cs_n_in,
    input  wire logic           si_in,
    output logic [7:0]          opcode_out,
    output fwp_pkg::fwp_addr_t  addr_out,
    output logic [2:0]          bytes_out,
    output logic [2:0]          bits_out,
    output logic                frame_tog_out
);
    import fwp_pkg::*;

    logic       fresh_q;
    logic [6:0] shift_q;
    logic [7:0] byte_now;
    logic       byte_done;

    // ============================================================
    // frame start marker
    // chip select high arms it; the first link edge of a frame clears it
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // byte assembled from the shift register and the current bit
    assign byte_now  = {shift_q, si_in};
    assign byte_done = !fresh_q && (bits_out == 3'h7);

    // ============================================================
    // bit and byte counting, sampled on the rising link edge
    // counts stay frozen after the frame so the core can read them
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            shift_q       <= 7'h00;
            bits_out      <= 3'h0;
            bytes_out     <= 3'h0;
            opcode_out    <= 8'h00;
            addr_out      <= 24'h000000;
            frame_tog_out <= 1'b0;
        end else if (fresh_q) begin
            shift_q       <= {6'h00, si_in};
            bits_out      <= 3'h1;
            bytes_out     <= 3'h0;
            frame_tog_out <= !frame_tog_out;
        end else begin
            shift_q  <= byte_now[6:0];
            bits_out <= bits_out + 3'h1;
            if (byte_done) begin
                if (bytes_out == 3'h0) begin
                    opcode_out <= byte_now;
                end else if (bytes_out != `FWP_BYTE_SAT) begin
                    addr_out <= {addr_out[15:0], byte_now};
                end
                if (bytes_out != `FWP_BYTE_SAT) begin
                    bytes_out <= bytes_out + 3'h1;
                end
            end
        end
    end

endmodule

/* File: hw/fwp_top.sv */
// write-enable latch and per-sector protection command logic
`include "fwp_cfg.svh"
module fwp_top #(
    parameter int SECTORS = `FWP_SECTORS
) (
    input  wire logic           CLK_IN,
    input  wire logic           RST_IN,
    input  wire logic           SCK_IN,
    input  wire logic           CS_N_IN,
    input  wire logic           SI_IN,
    input  wire logic           PROTECT_REGS_LOCK_IN,
    input  wire logic           PE_REQ_IN,
    input  wire fwp_pkg::fwp_addr_t PE_ADDR_IN,
    input  wire logic           PE_CHIP_IN,
    input  wire logic           SRW_REQ_IN,
    input  wire logic           LATCH_CLR_IN,
    output logic                WRITE_ENABLE_LATCH_OUT,
    output fwp_pkg::fwp_sect_t  SECTOR_PROTECT_OUT,
    output logic                SEQ_PROG_EXIT_OUT,
    output logic                PE_GRANT_OUT,
    output logic                PE_DENY_OUT,
    output logic                SRW_GRANT_OUT,
    output logic                SRW_DENY_OUT
);
    import fwp_pkg::*;

    // ============================================================
    // helper functions
    // sector index from a byte address; the low bits are ignored
    function automatic fwp_sidx_t sector_of(input fwp_addr_t a);
        sector_of = a[`FWP_SECTOR_MSB:`FWP_SECTOR_LSB];
    endfunction

    // a frame is whole when enough bytes came and it ends on a boundary
    function automatic logic frame_whole(input logic [2:0] nbytes,
                                         input logic [2:0] nbits,
                                         input logic [2:0] need);
        frame_whole = (nbytes >= need) && (nbits == 3'h0);
    endfunction

    // ============================================================
    // link side wires
    logic [7:0] rx_opcode;
    fwp_addr_t  rx_addr;
    logic [2:0] rx_bytes;
    logic [2:0] rx_bits;
    logic       rx_tog;

    // the receiver runs on the link clock; its words are read by the
    // core only after chip select has risen and the link clock stopped
    fwp_link_rx u_rx (
        .sck_in        (SCK_IN),
        .rst_in        (RST_IN),
        .cs_n_in       (CS_N_IN),
        .si_in         (SI_IN),
        .opcode_out    (rx_opcode),
        .addr_out      (rx_addr),
        .bytes_out     (rx_bytes),
        .bits_out      (rx_bits),
        .frame_tog_out (rx_tog)
    );

    // ============================================================
    // crossings into the core clock
    logic cs_s1_q;
    logic cs_s2_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic seen_tog_q;

    // two flops per level; only the second flop is read by logic
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
        end else begin
            cs_s1_q  <= CS_N_IN;
            cs_s2_q  <= cs_s1_q;
            tog_s1_q <= rx_tog;
            tog_s2_q <= tog_s1_q;
        end
    end

    // ============================================================
    // frame tracker
    fwp_state_e state_q;
    fwp_state_e state_d;

    // a frame is executed once, after chip select is seen high again
    always_comb begin
        state_d = state_q;
        case (state_q)
            FWP_ST_IDLE: begin
                if (!cs_s2_q) begin
                    state_d = FWP_ST_FRAME;
                end
            end
            FWP_ST_FRAME: begin
                if (cs_s2_q) begin
                    state_d = FWP_ST_EXEC;
                end
            end
            FWP_ST_EXEC: begin
                state_d = FWP_ST_IDLE;
            end
            default: begin
                state_d = FWP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_q <= FWP_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // remember which link frame has been consumed
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            seen_tog_q <= 1'b0;
        end else if (state_q == FWP_ST_EXEC) begin
            seen_tog_q <= tog_s2_q;
        end
    end

    // ============================================================
    // latch and protection state, declared ahead of the decode that
    // reads them; both live only in the core clock domain
    logic      latch_q;
    logic      latch_d;
    fwp_sect_t prot_q;
    fwp_sect_t prot_d;

    // ============================================================
    // command decode at frame end
    // a frame with no link edges carries stale words and is dropped
    wire exec_now    = (state_q == FWP_ST_EXEC);
    wire had_clocks  = (tog_s2_q != seen_tog_q);
    wire frame_end   = exec_now && had_clocks;
    wire op_set      = (rx_opcode == `FWP_OP_LATCH_SET);
    wire op_clr      = (rx_opcode == `FWP_OP_LATCH_CLEAR);
    wire op_prot     = (rx_opcode == `FWP_OP_PROTECT);
    wire op_unprot   = (rx_opcode == `FWP_OP_UNPROTECT);
    wire op_sector   = op_prot || op_unprot;
    wire op_whole    = frame_whole(rx_bytes, rx_bits, `FWP_OPCODE_BYTES);
    wire adr_whole   = frame_whole(rx_bytes, rx_bits, `FWP_ADDR_BYTES);
    wire fwp_sidx_t cmd_sector = sector_of(rx_addr);

    // latch set and clear only act on a whole, aligned frame
    wire do_latch_set = frame_end && op_set && op_whole;
    wire do_latch_clr = frame_end && op_clr && op_whole;

    // sector commands are ignored entirely without the latch
    wire sect_armed   = frame_end && op_sector && latch_q;
    wire sect_locked  = sect_armed && PROTECT_REGS_LOCK_IN;
    wire sect_write   = sect_armed && !PROTECT_REGS_LOCK_IN
                        && adr_whole;

    // ============================================================
    // program and erase gate
    // a chip-wide erase is refused while any sector is protected
    wire pe_blocked = PE_CHIP_IN ? (|prot_q)
                                 : prot_q[sector_of(PE_ADDR_IN)];
    wire pe_ok      = PE_REQ_IN && latch_q && !pe_blocked;
    wire pe_ng      = PE_REQ_IN && !pe_ok;
    wire srw_ok     = SRW_REQ_IN && latch_q;
    wire srw_ng     = SRW_REQ_IN && !latch_q;

    // ============================================================
    // write-enable latch
    // clears come first so a set arriving in the same cycle wins
    always_comb begin
        latch_d = latch_q;
        if (do_latch_clr || sect_armed || pe_ng || LATCH_CLR_IN) begin
            latch_d = 1'b0;
        end
        if (do_latch_set) begin
            latch_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            latch_q <= `FWP_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ============================================================
    // sector protection bits
    // a locked or short command leaves every bit as it was
    always_comb begin
        prot_d = prot_q;
        if (sect_write) begin
            prot_d[cmd_sector] = op_prot;
        end
    end

    // every sector comes out of reset protected
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            prot_q <= {SECTORS{`FWP_PROT_RST}};
        end else begin
            prot_q <= prot_d;
        end
    end

    // ============================================================
    // answer pulses, registered so they never glitch
    logic seq_exit_q;
    logic pe_grant_q;
    logic pe_deny_q;
    logic srw_grant_q;
    logic srw_deny_q;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            seq_exit_q  <= 1'b0;
            pe_grant_q  <= 1'b0;
            pe_deny_q   <= 1'b0;
            srw_grant_q <= 1'b0;
            srw_deny_q  <= 1'b0;
        end else begin
            seq_exit_q  <= do_latch_clr;
            pe_grant_q  <= pe_ok;
            pe_deny_q   <= pe_ng;
            srw_grant_q <= srw_ok;
            srw_deny_q  <= srw_ng;
        end
    end

    // ============================================================
    // outputs
    assign WRITE_ENABLE_LATCH_OUT = latch_q;
    assign SECTOR_PROTECT_OUT     = prot_q;
    assign SEQ_PROG_EXIT_OUT      = seq_exit_q;
    assign PE_GRANT_OUT           = pe_grant_q;
    assign PE_DENY_OUT            = pe_deny_q;
    assign SRW_GRANT_OUT          = srw_grant_q;
    assign SRW_DENY_OUT           = srw_deny_q;

endmodule

/* File: test/fwp_chk_sva.sv */
// concurrent checks on the ports of the sector protect block
module fwp_chk #(
    parameter int SECTORS = 16
) (
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        CS_N_IN,
    input wire logic        PROTECT_REGS_LOCK_IN,
    input wire logic        PE_REQ_IN,
    input wire logic [23:0] PE_ADDR_IN,
    input wire logic        PE_CHIP_IN,
    input wire logic        SRW_REQ_IN,
    input wire logic        WRITE_ENABLE_LATCH_OUT,
    input wire logic [15:0] SECTOR_PROTECT_OUT,
    input wire logic        PE_GRANT_OUT,
    input wire logic        PE_DENY_OUT,
    input wire logic        SRW_GRANT_OUT,
    input wire logic        SRW_DENY_OUT
);
    import fwp_pkg::*;

    // ==========
    // short names; bad means the program or erase must be refused
    wire logic      write_enable_latch = WRITE_ENABLE_LATCH_OUT;
    wire fwp_sect_t sp  = SECTOR_PROTECT_OUT;
    wire logic      hit = sp[PE_ADDR_IN[19:16]];
    wire logic      bad = !write_enable_latch || hit || (PE_CHIP_IN && |sp);

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // a frame well under way, and a lock that has stood long enough
    sequence s_in_frame;
        !CS_N_IN [*3];
    endsequence
    sequence s_locked;
        PROTECT_REGS_LOCK_IN [*6];
    endsequence

    // ==========
    // permission answers
    pe_answer_a: assert property (
        PE_REQ_IN |=> PE_GRANT_OUT != PE_DENY_OUT)
        else $error("program request not answered once");
    pe_deny_a: assert property (
        PE_REQ_IN && bad |=> PE_DENY_OUT && !write_enable_latch)
        else $error("refused program not denied or latch kept");
    pe_grant_a: assert property (
        PE_REQ_IN && !bad |=> PE_GRANT_OUT)
        else $error("allowed program not granted");
    srw_gate_a: assert property (
        SRW_REQ_IN |=> SRW_GRANT_OUT == $past(write_enable_latch)
            && SRW_DENY_OUT != SRW_GRANT_OUT)
        else $error("status write answer does not follow latch");

    // ==========
    // protection bits
    sp_reset_a: assert property (disable iff (1'b0)
        RST_IN |=> sp == 16'hFFFF && !write_enable_latch)
        else $error("reset did not protect all sectors");
    frame_quiet_a: assert property (
        s_in_frame |-> $stable(sp))
        else $error("protect bits changed inside a frame");
    lock_hold_a: assert property (
        s_locked |-> $stable(sp))
        else $error("locked protect bits changed");
    bit_latch_a: assert property (
        !$stable(sp) |-> $fell(write_enable_latch))
        else $error("protect change without latch clear");
endmodule

/* File: test/fwp_host.sv */
// link-side host model: drives framed commands on the serial pins
module fwp_host (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========
    // idle pins: clock parked low, select high
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // one frame of n bits, msb first; the clock runs only inside it
    task automatic send(input logic [39:0] v, input int n);
        cs_n_out = 1'b0;
        #61.3;
        for (int i = n - 1; i >= 0; i--) begin
            si_out = v[i];
            #3 sck_out = 1'b1;
            #3 sck_out = 1'b0;
        end
        // released data line flips so it never holds the last bit sent
        si_out = ~si_out;
        #70 cs_n_out = 1'b1;
        #400;
    endtask
endmodule

/* File: test/tb_fwp_top.sv */
// self-checking bench for the sector protect block
module tb_fwp_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fwp_pkg::*;

    // ==========
    // stimulus and observed pins
    logic        clk, rst, lock, pe_req, pe_chip, srw_req, lclr;
    fwp_addr_t   pe_addr;
    wire         sck, cs_n, si, write_enable_latch, sq, peg, ped, srg, srd;
    fwp_sect_t   sp;
    fwp_sect_t   esp;
    logic [16:0] ans;
    int          mismatches = 0, n_tests = 0, n_exit = 0, cyc = 0;

    fwp_top dut (
        .CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n),
        .SI_IN(si), .PROTECT_REGS_LOCK_IN(lock), .PE_REQ_IN(pe_req),
        .PE_ADDR_IN(pe_addr), .PE_CHIP_IN(pe_chip),
        .SRW_REQ_IN(srw_req), .LATCH_CLR_IN(lclr),
        .WRITE_ENABLE_LATCH_OUT(write_enable_latch), .SECTOR_PROTECT_OUT(sp),
        .SEQ_PROG_EXIT_OUT(sq), .PE_GRANT_OUT(peg), .PE_DENY_OUT(ped),
        .SRW_GRANT_OUT(srg), .SRW_DENY_OUT(srd)
    );
    fwp_host u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));

    always #20 clk = ~clk;

    // pulse tally and watchdog; a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sq === 1'b1)
            n_exit <= n_exit + 1;
        if (cyc == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    // ==========
    // shared tasks
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic fr(input logic [39:0] v, input int n);
        u_host.send(v, n);
    endtask

    // answer pulses stand one cycle, so they are caught just past it
    task automatic req(input logic s, input fwp_addr_t a, input logic c);
        @(posedge clk);
        pe_req <= !s;
        srw_req <= s;
        pe_addr <= a;
        pe_chip <= c;
        @(posedge clk);
        pe_req <= 1'b0;
        srw_req <= 1'b0;
        #1 ans = {15'h0, s ? {srg, srd} : {peg, ped}};
    endtask

    // ==========
    // scenarios
    task automatic t_latch();
        fr(16'h06FF, 16);
        chk({write_enable_latch, sp}, {1'b1, esp});
        fr(8'h00, 5);
        fr(12'h040, 12);
        fr(0, 0);
        chk({write_enable_latch, sp}, {1'b1, esp});
        fr(16'h0412, 16);
        chk({write_enable_latch, sp}, {1'b0, esp});
        chk(17'(n_exit), 17'h1);
        fr(7'h03, 7);
        chk({write_enable_latch, sp}, {1'b0, esp});
        fr(8'h06, 8);
        @(posedge clk) lclr <= 1'b1;
        @(posedge clk) lclr <= 1'b0;
        #1 chk({write_enable_latch, sp}, {1'b0, esp});
    endtask

    task automatic t_guard();
        req(1'b0, 24'h350000, 1'b0);
        chk(ans, 17'h1);
        req(1'b1, 24'h0, 1'b0);
        chk(ans, 17'h1);
        fr({8'h39, 24'h350000}, 32);
        chk({write_enable_latch, sp}, {1'b0, esp});
    endtask

    task automatic t_unprot();
        fwp_addr_t a [3] = '{24'h35ABCD, 24'h000000, 24'hFFFFFF};
        foreach (a[i]) begin
            fr(8'h06, 8);
            fr({8'h39, a[i], 8'hA5}, 40);
            esp[a[i][19:16]] = 1'b0;
            chk({write_enable_latch, sp}, {1'b0, esp});
        end
        fr(8'h06, 8);
        req(1'b0, 24'h35FFFF, 1'b0);
        chk(ans, 17'h2);
        req(1'b1, 24'h0, 1'b0);
        chk(ans, 17'h2);
        req(1'b0, 24'h050000, 1'b1);
        chk(ans, 17'h1);
        chk({write_enable_latch, sp}, {1'b0, esp});
        fr(8'h06, 8);
        req(1'b0, 24'h46FFFF, 1'b0);
        chk(ans, 17'h1);
    endtask

    // short and ragged sector frames keep the bits but drop the latch; a whole frame then protects sector 5
    task automatic t_short();
        fr(8'h06, 8);
        fr({8'h39, 16'h0700}, 24);
        chk({write_enable_latch, sp}, {1'b0, esp});
        fr(8'h06, 8);
        fr({8'h36, 24'h000000, 1'b0}, 33);
        chk({write_enable_latch, sp}, {1'b0, esp});
        fr(8'h06, 8);
        fr({8'h36, 24'h350001}, 32);
        esp[5] = 1'b1;
        chk({write_enable_latch, sp}, {1'b0, esp});
    endtask

    task automatic t_lock();
        @(posedge clk) lock <= 1'b1;
        fr(8'h06, 8);
        fr({8'h36, 24'h000000}, 32);
        chk({write_enable_latch, sp}, {1'b0, esp});
        fr(8'h06, 8);
        fr({8'h39, 24'h350000}, 32);
        chk({write_enable_latch, sp}, {1'b0, esp});
        @(posedge clk) lock <= 1'b0;
    endtask

    // a second reset in mid-run must protect every sector again
    task automatic t_rst();
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        esp = '1;
        #1 chk({write_enable_latch, sp}, {1'b0, esp});
    endtask

    // ==========
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        lock = 1'b0;
        pe_req = 1'b0;
        pe_chip = 1'b0;
        srw_req = 1'b0;
        lclr = 1'b0;
        pe_addr = '0;
        esp = '1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk({write_enable_latch, sp}, {1'b0, esp});
        t_latch();
        t_guard();
        t_unprot();
        t_short();
        t_lock();
        t_rst();
        complete_run();
    end
endmodule

bind fwp_top fwp_chk #(.SECTORS(SECTORS)) u_chk (.*);
